/* File: test/ewf_regs_bench.sv */
// self-checking bench for the exposure window and frame stamp registers.
// assumes an avalon slave that may stretch waitrequest; 100 MHz clock.
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("unexpected at %0t: got %h want %h", $time, \
  (got), (exp)); end end
module ewf_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ewf_pkg::*;
  // distinct halves so a swapped half cannot pass
  localparam logic [31:0] POS = 32'h0004_0002;
  localparam logic [31:0] SIZE = 32'h0008_0010;
  localparam logic [9:0] ITEMS = 10'h2fe;
  logic clk;
  logic nrst;
  ewf_req_s req;
  logic waitrequest, readdatavalid, window_on, insert_absolute;
  logic [31:0] readdata, readdata_q, rd, rd_q;
  ewf_pair_s window_origin, window_extent;
  logic [9:0] insert_select, insert_select_q;
  logic window_on_q;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;

  ewf_regs #(.QUAD_TAP(1'b0), .ITEMS_SUPPORTED(ITEMS), .ABS_SUPPORTED(1'b0),
    .POS_UNIT(POS), .SIZE_UNIT(SIZE)) dut (.clk(clk), .nrst(nrst),
    .req(req), .waitrequest(waitrequest), .readdatavalid(readdatavalid),
    .readdata(readdata), .window_on(window_on),
    .window_origin(window_origin), .window_extent(window_extent),
    .insert_select(insert_select), .insert_absolute(insert_absolute));
  // quad-tap build shares the bus; it answers in step with dut
  ewf_regs #(.QUAD_TAP(1'b1), .ITEMS_SUPPORTED(ITEMS), .ABS_SUPPORTED(1'b0),
    .POS_UNIT(POS), .SIZE_UNIT(SIZE)) dut_quad (.clk(clk), .nrst(nrst),
    .req(req), .waitrequest(), .readdatavalid(), .readdata(readdata_q),
    .window_on(window_on_q), .window_origin(), .window_extent(),
    .insert_select(insert_select_q), .insert_absolute());

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // whole run is under a hundred cycles; ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  // request held until the rising edge where waitrequest is seen low
  task automatic bus(input logic wr, input logic [15:0] a,
      input logic [31:0] d);
    @(posedge clk);
    req.address <= a;
    req.writedata <= d;
    req.write <= wr;
    req.read <= !wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    rd_q = readdata_q;
    req.read <= 1'b0;
    req.write <= 1'b0;
    // let register updates from the accept edge settle
    @(negedge clk);
  endtask : bus

  task automatic t_idents;
    logic [15:0] base;
    bus(1'b0, EWF_OFF_CTRL, 32'h0);
    `CHK(rd, 32'h8000_0000)
    `CHK(readdatavalid, 1'b1)
    `CHK(rd_q, 32'h0)
    bus(1'b1, EWF_OFF_PTR, 32'h1234_5678);
    bus(1'b0, EWF_OFF_PTR, 32'h0);
    `CHK(rd[31:28], 4'h3)
    `CHK(rd_q, 32'h0)
    `CHK(rd << 2, {4'hf, 12'h0, EWF_OFF_BASE})
    // software path: times four, drop the leading f digit
    base = 16'(rd << 2);
    bus(1'b0, base, 32'h0);
    `CHK(rd, POS)
    bus(1'b0, base + 16'h4, 32'h0);
    `CHK(rd, SIZE)
    bus(1'b1, 16'h1000, 32'hffff_ffff);
    bus(1'b0, 16'h1000, 32'h0);
    `CHK(rd, 32'h0)
  endtask : t_idents

  task automatic t_window;
    bus(1'b1, EWF_OFF_ORIGIN, 32'h0030_0040);
    bus(1'b0, EWF_OFF_ORIGIN, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(window_origin, 32'h0)
    bus(1'b1, EWF_OFF_CTRL, 32'hffff_ffff);
    bus(1'b0, EWF_OFF_CTRL, 32'h0);
    `CHK(rd, 32'h8200_0000)
    `CHK(window_on, 1'b1)
    `CHK(window_on_q, 1'b0)
    bus(1'b1, EWF_OFF_ORIGIN, 32'h0030_0040);
    bus(1'b0, EWF_OFF_ORIGIN, 32'h0);
    `CHK(rd, 32'h0030_0040)
    `CHK(rd_q, 32'h0)
    // msb-first: left sits in the upper half, top in the lower
    `CHK(window_origin.horiz, 16'h0030)
    `CHK(window_origin.vert, 16'h0040)
    bus(1'b1, EWF_OFF_EXTENT, 32'h0050_0060);
    `CHK(window_extent.horiz, 16'h0050)
    `CHK(window_extent.vert, 16'h0060)
    bus(1'b1, EWF_OFF_CTRL, 32'h0);
    `CHK(window_on, 1'b0)
    bus(1'b1, EWF_OFF_ORIGIN, 32'h1111_2222);
    bus(1'b0, EWF_OFF_ORIGIN, 32'h0);
    `CHK(rd, 32'h0030_0040)
  endtask : t_window

  task automatic t_meta;
    logic [31:0] inq;
    inq = 32'h8000_0000 | {6'h0, ITEMS, 16'h0};
    bus(1'b0, EWF_OFF_META, 32'h0);
    `CHK(rd, inq)
    `CHK(rd_q, inq & ~32'h0200_0000)
    bus(1'b1, EWF_OFF_META, 32'hffff_ffff);
    bus(1'b0, EWF_OFF_META, 32'h0);
    `CHK(rd, inq | {22'h0, ITEMS})
    `CHK(insert_select, ITEMS)
    `CHK(insert_absolute, 1'b0)
    bus(1'b1, EWF_OFF_META, 32'h0);
    `CHK(insert_select, 10'h000)
    // only the window position selection
    bus(1'b1, EWF_OFF_META, 32'h0000_0200);
    `CHK(insert_select, 10'h200)
    `CHK(insert_select_q, 10'h000)
  endtask : t_meta

  initial begin
    nrst = 1'b0;
    req = '{address: 16'h0, read: 1'b0, write: 1'b0,
      writedata: 32'h0, byteenable: 4'hf};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_idents();
    t_window();
    t_meta();
    close_out();
  end
endmodule : ewf_regs_bench
`default_nettype wire

/* File: verilog/ewf_pkg.sv */
// constants, offsets and field layout for the exposure window and
// frame stamp register bank; assumes a 32-bit avalon-mm slave bus.
// How it works
// RULE_01: quad-tap sensor builds offer no exposure window feature at all.
// RULE_02: software reads pointer, times four, drops leading f digit.
// RULE_03: pointer register returns quadlet offset of the window block.
// RULE_04: bit 0 of each feature control reads 1 when implemented.
// RULE_05: control bit 6 turns window on or off and reads back.
// RULE_06: while window is off, its position and size ignore writes.
// RULE_07: granularity registers: horizontal in bits 0-15, vertical 16-31.
// RULE_08: origin holds left/top, extent holds width/height, same halves.
// RULE_09: metadata bits 6-15 read 1 for each supported embeddable item.
// RULE_10: bit 16 selects relative or absolute; relative when unsupported.
// RULE_11: relative/absolute select is read-only; writes do not change it.
// RULE_12: metadata bit 22 enables window position insertion per frame.
// RULE_13: bit 0 is the msb; reserved bits read as zero.
// RULE_14: selection bit 1 inserts item in later frames, 0 stops it.
`default_nettype none
package ewf_pkg;
  localparam logic [15:0] EWF_OFF_META = 16'h12f8;
  localparam logic [15:0] EWF_OFF_CTRL = 16'h1a70;
  localparam logic [15:0] EWF_OFF_PTR = 16'h1a74;
  // window block base, byte address; pointer reads base/4 with 3c prefix, f after times four
  localparam logic [15:0] EWF_OFF_BASE = 16'h1a80;
  localparam logic [15:0] EWF_OFF_POS_UNIT = 16'h1a80;
  localparam logic [15:0] EWF_OFF_SIZE_UNIT = 16'h1a84;
  localparam logic [15:0] EWF_OFF_ORIGIN = 16'h1a88;
  localparam logic [15:0] EWF_OFF_EXTENT = 16'h1a8c;
  localparam logic [31:0] EWF_PTR_PREFIX = 32'h3c00_0000;
  // msb-first numbering: documented bit n is vector bit 31-n
  localparam int EWF_BIT_PRESENT = 31;
  localparam int EWF_BIT_ON = 25;
  localparam int EWF_BIT_ABS = 15;
  localparam int EWF_BIT_POS_SEL = 9;
  localparam logic [31:0] EWF_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] EWF_HALF_RESET = 32'h0000_0000;
  localparam logic [31:0] EWF_META_RESET = 32'h0000_0000;
  // selection bits 22..31 sit at vector bits 9..0
  localparam logic [9:0] EWF_SEL_MASK = 10'h3ff;
  localparam logic [31:0] EWF_UNMAPPED = 32'h0000_0000;
  // msb-first: left/width in the upper half, top/height in the lower
  typedef struct packed {
    logic [15:0] horiz;
    logic [15:0] vert;
  } ewf_pair_s;
  typedef struct packed {
    logic [15:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ewf_req_s;
endpackage : ewf_pkg
`default_nettype wire

/* File: verilog/ewf_regs.sv */
// register bank for the exposure window and frame stamp selections.
// assumes an avalon-mm master on clk; answers in one cycle.
//
// Our own choice: the Avalon-MM interface to the registers.
`default_nettype none
module ewf_regs #(
  parameter bit QUAD_TAP = 1'b0,
  parameter logic [9:0] ITEMS_SUPPORTED = 10'h3ff,
  parameter bit ABS_SUPPORTED = 1'b0,
  parameter logic [31:0] POS_UNIT = 32'h0001_0001,
  parameter logic [31:0] SIZE_UNIT = 32'h0001_0001
) (
  input wire logic clk,
  input wire logic nrst,
  input wire ewf_pkg::ewf_req_s req,
  output logic waitrequest,
  output logic readdatavalid,
  output logic [31:0] readdata,
  output logic window_on,
  output ewf_pkg::ewf_pair_s window_origin,
  output ewf_pkg::ewf_pair_s window_extent,
  output logic [9:0] insert_select,
  output logic insert_absolute
);
  import ewf_pkg::*;

  logic ack_reg, ack_next;
  logic on_reg, on_next;
  logic [31:0] origin_reg, origin_next;
  logic [31:0] extent_reg, extent_next;
  logic [9:0] sel_reg, sel_next;
  logic [31:0] rd_reg, rd_next;
  logic rv_reg, rv_next;
  logic win_ok;
  logic [31:0] bemask;

  // RULE_01 feature absent on quad-tap builds
  assign win_ok = !QUAD_TAP;
  assign bemask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                   {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
  // one wait cycle per access, then the accept edge
  assign waitrequest = (req.read || req.write) && !ack_reg;

  always_comb begin
    ack_next = 1'b0;
    on_next = on_reg;
    origin_next = origin_reg;
    extent_next = extent_reg;
    sel_next = sel_reg;
    rd_next = rd_reg;
    rv_next = 1'b0;
    if ((req.read || req.write) && !ack_reg) begin
      ack_next = 1'b1;
    end
    if (req.write && ack_reg) begin
      unique case (req.address)
        EWF_OFF_CTRL: begin
          // RULE_05 on/off control
          if (win_ok && req.byteenable[3]) begin
            on_next = req.writedata[EWF_BIT_ON];
          end
        end
        EWF_OFF_ORIGIN: begin
          // RULE_06 frozen while off
          if (win_ok && on_reg) begin
            origin_next = (origin_reg & ~bemask) | (req.writedata & bemask);
          end
        end
        EWF_OFF_EXTENT: begin
          // RULE_06 frozen while off
          if (win_ok && on_reg) begin
            extent_next = (extent_reg & ~bemask) | (req.writedata & bemask);
          end
        end
        EWF_OFF_META: begin
          // RULE_14 selection bits; RULE_11 abs bit not stored
          sel_next = (sel_reg & ~bemask[9:0])
                   | (req.writedata[9:0] & bemask[9:0] & ITEMS_SUPPORTED);
          // RULE_12 position insertion needs the window feature
          if (!win_ok) begin
            sel_next[EWF_BIT_POS_SEL] = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (req.read && ack_reg) begin
      rv_next = 1'b1;
    end
    // read word is captured in the wait cycle so it leaves a flip-flop
    // and stands at the accept edge; no write can land in between
    if (req.read && !ack_reg) begin
      // RULE_13 reserved bits and unmapped words read zero
      rd_next = EWF_UNMAPPED;
      unique case (req.address)
        EWF_OFF_CTRL: begin
          // RULE_04 presence bit
          rd_next[EWF_BIT_PRESENT] = win_ok;
          rd_next[EWF_BIT_ON] = on_reg;
        end
        EWF_OFF_PTR: begin
          // RULE_03 quadlet pointer to window block
          if (win_ok) begin
            rd_next = EWF_PTR_PREFIX | {18'h0, EWF_OFF_BASE[15:2]};
          end
        end
        // RULE_07 granularity, horizontal in upper half
        EWF_OFF_POS_UNIT: rd_next = win_ok ? POS_UNIT : EWF_UNMAPPED;
        EWF_OFF_SIZE_UNIT: rd_next = win_ok ? SIZE_UNIT : EWF_UNMAPPED;
        // RULE_08 left/top and width/height halves
        EWF_OFF_ORIGIN: rd_next = win_ok ? origin_reg : EWF_UNMAPPED;
        EWF_OFF_EXTENT: rd_next = win_ok ? extent_reg : EWF_UNMAPPED;
        EWF_OFF_META: begin
          rd_next[EWF_BIT_PRESENT] = 1'b1;
          // RULE_09 item availability, bits 6..15
          rd_next[25:16] = {ITEMS_SUPPORTED[9] & win_ok,
                            ITEMS_SUPPORTED[8:0]};
          // RULE_10 fixed at relative unless absolute supported
          rd_next[EWF_BIT_ABS] = ABS_SUPPORTED;
          rd_next[9:0] = sel_reg;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      on_reg <= EWF_CTRL_RESET[EWF_BIT_ON];
      origin_reg <= EWF_HALF_RESET;
      extent_reg <= EWF_HALF_RESET;
      sel_reg <= EWF_META_RESET[9:0];
      rd_reg <= EWF_UNMAPPED;
      rv_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      on_reg <= on_next;
      origin_reg <= origin_next;
      extent_reg <= extent_next;
      sel_reg <= sel_next;
      rd_reg <= rd_next;
      rv_reg <= rv_next;
    end
  end

  // read data comes straight from the register loaded in the wait cycle
  assign readdata = rd_reg;
  assign readdatavalid = rv_reg;
  assign window_on = on_reg;
  assign window_origin = origin_reg;
  assign window_extent = extent_reg;
  // RULE_14 selection drives frame insertion
  assign insert_select = sel_reg & EWF_SEL_MASK;
  // RULE_10 relative embedded when absolute unsupported
  assign insert_absolute = ABS_SUPPORTED;

  property p_frozen_off;
    @(posedge clk) disable iff (!nrst)
      !on_reg |=> origin_reg == $past(origin_reg);
  endproperty
  a_frozen_off: assert property (p_frozen_off) // RULE_06
    else $error("origin changed while window off");

  property p_extent_frozen;
    @(posedge clk) disable iff (!nrst)
      !on_reg |=> extent_reg == $past(extent_reg);
  endproperty
  a_extent_frozen: assert property (p_extent_frozen) // RULE_06
    else $error("extent changed while window off");

  property p_on_write;
    @(posedge clk) disable iff (!nrst)
      (req.write && ack_reg && req.address == EWF_OFF_CTRL && win_ok
       && req.byteenable[3]) |=> on_reg == $past(req.writedata[EWF_BIT_ON]);
  endproperty
  a_on_write: assert property (p_on_write) // RULE_05
    else $error("on bit not taken");

  property p_quad;
    @(posedge clk) disable iff (!nrst)
      QUAD_TAP |-> !on_reg && insert_select[EWF_BIT_POS_SEL] == 1'b0;
  endproperty
  a_quad: assert property (p_quad) // RULE_01
    else $error("window active on quad-tap build");

  property p_presence;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_CTRL)
        |-> readdata[EWF_BIT_PRESENT] == !QUAD_TAP;
  endproperty
  a_presence: assert property (p_presence) // RULE_04
    else $error("presence bit wrong");

  property p_ptr;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_PTR && win_ok)
        |-> readdata[13:0] == EWF_OFF_BASE[15:2];
  endproperty
  a_ptr: assert property (p_ptr) // RULE_03
    else $error("pointer value wrong");

  property p_abs_fixed;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_META)
        |-> readdata[EWF_BIT_ABS] == ABS_SUPPORTED;
  endproperty
  a_abs_fixed: assert property (p_abs_fixed) // RULE_11
    else $error("absolute select changed");

  property p_reserved;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_META)
        |-> readdata[26 +: 5] == 5'h00 && readdata[14:10] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) // RULE_13
    else $error("reserved bits nonzero");

  property p_sel;
    @(posedge clk) disable iff (!nrst)
      (req.write && ack_reg && req.address == EWF_OFF_META
       && req.byteenable[0] && req.byteenable[1] && win_ok)
        |=> insert_select == ($past(req.writedata[9:0]) & ITEMS_SUPPORTED);
  endproperty
  a_sel: assert property (p_sel) // RULE_14
    else $error("selection not applied");

  property p_wait;
    @(posedge clk) disable iff (!nrst)
      (req.read && !ack_reg) |-> waitrequest ##1 !waitrequest;
  endproperty
  a_wait: assert property (p_wait) // Avalon-MM: one wait cycle per read access
    else $error("bus did not answer in one cycle");

  property p_on_hold;
    @(posedge clk) disable iff (!nrst)
      !(req.write && ack_reg && req.address == EWF_OFF_CTRL)
        |=> $stable(on_reg);
  endproperty
  a_on_hold: assert property (p_on_hold) // RULE_05
    else $error("on bit changed without a control write");

  property p_on_read;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_CTRL)
        |-> readdata[EWF_BIT_ON] == on_reg;
  endproperty
  a_on_read: assert property (p_on_read) // RULE_05
    else $error("on bit reads back wrong");

  property p_ctrl_reserved;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_CTRL)
        |-> readdata[30:26] == 5'h00 && readdata[24:0] == 25'h0;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) // RULE_13
    else $error("control reserved bits nonzero");

  property p_ctrl_quad;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_CTRL && QUAD_TAP)
        |-> readdata == 32'h0000_0000;
  endproperty
  a_ctrl_quad: assert property (p_ctrl_quad) // RULE_01
    else $error("control word nonzero on quad-tap build");

  property p_ptr_quad;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_PTR && QUAD_TAP)
        |-> readdata == 32'h0000_0000;
  endproperty
  a_ptr_quad: assert property (p_ptr_quad) // RULE_01
    else $error("pointer nonzero on quad-tap build");

  property p_pos_unit;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_POS_UNIT && !QUAD_TAP)
        |-> readdata == POS_UNIT;
  endproperty
  a_pos_unit: assert property (p_pos_unit) // RULE_07
    else $error("position granularity wrong");

  property p_size_unit;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_SIZE_UNIT && !QUAD_TAP)
        |-> readdata == SIZE_UNIT;
  endproperty
  a_size_unit: assert property (p_size_unit) // RULE_07
    else $error("size granularity wrong");

  property p_origin_read;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_ORIGIN && !QUAD_TAP)
        |-> readdata == window_origin;
  endproperty
  a_origin_read: assert property (p_origin_read) // RULE_08
    else $error("origin reads back wrong");

  property p_extent_read;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_EXTENT && !QUAD_TAP)
        |-> readdata == window_extent;
  endproperty
  a_extent_read: assert property (p_extent_read) // RULE_08
    else $error("extent reads back wrong");

  property p_origin_write;
    @(posedge clk) disable iff (!nrst)
      (req.write && ack_reg && req.address == EWF_OFF_ORIGIN && on_reg
       && !QUAD_TAP && req.byteenable == 4'hf)
        |=> window_origin == $past(req.writedata);
  endproperty
  a_origin_write: assert property (p_origin_write) // RULE_08
    else $error("origin write not taken");

  property p_extent_write;
    @(posedge clk) disable iff (!nrst)
      (req.write && ack_reg && req.address == EWF_OFF_EXTENT && on_reg
       && !QUAD_TAP && req.byteenable == 4'hf)
        |=> window_extent == $past(req.writedata);
  endproperty
  a_extent_write: assert property (p_extent_write) // RULE_08
    else $error("extent write not taken");

  property p_items;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_META)
        |-> readdata[24:16] == ITEMS_SUPPORTED[8:0]
            && readdata[25] == (ITEMS_SUPPORTED[9] && !QUAD_TAP);
  endproperty
  a_items: assert property (p_items) // RULE_09
    else $error("item availability wrong");

  property p_sel_read;
    @(posedge clk) disable iff (!nrst)
      (req.read && ack_reg && req.address == EWF_OFF_META)
        |-> readdata[9:0] == insert_select;
  endproperty
  a_sel_read: assert property (p_sel_read) // RULE_14
    else $error("selection reads back wrong");

  property p_sel_supported;
    @(posedge clk) disable iff (!nrst)
      (insert_select & ~ITEMS_SUPPORTED) == 10'h000;
  endproperty
  a_sel_supported: assert property (p_sel_supported) // RULE_09
    else $error("unsupported item selected");

  property p_sel_hold;
    @(posedge clk) disable iff (!nrst)
      !(req.write && ack_reg && req.address == EWF_OFF_META)
        |=> $stable(insert_select);
  endproperty
  a_sel_hold: assert property (p_sel_hold) // RULE_14
    else $error("selection changed without a metadata write");
endmodule : ewf_regs
`default_nettype wire
